// ### hdl/xc_params.svh
`ifndef XC_PARAMS_SVH
`define XC_PARAMS_SVH

// Traffic and matrix geometry
`define XC_BYTE_W 8
`define XC_WORD_W 32
`define XC_SLOTS 480
`define XC_HALF (`XC_SLOTS / 2)
`define XC_POS_W 9
`define XC_CTR_PORTS 32
`define XC_SPARE_CTR (`XC_CTR_PORTS - 1)

// Timing (frequencies in kHz)
`define XC_REF_KHZ 16384
`define XC_RATE_KHZ 27648
`define XC_CTRL_KHZ 6912
`define XC_NCO_MOD 16
`define XC_NCO_INC ((`XC_RATE_KHZ * `XC_NCO_MOD) / `XC_REF_KHZ - `XC_NCO_MOD)
`define XC_CDIV_HALF ((`XC_RATE_KHZ / `XC_CTRL_KHZ) / 2)
`define XC_SYNC_DIV 224
`define XC_GAP_N 432

// Command word fields
`define XC_OP_LO 28
`define XC_F_DIR 27
`define XC_F_POS_LO 18
`define XC_F_SRC_LO 9
`define XC_F_PROT 10
`define XC_F_GAP 9
`define XC_F_ACT 8
`define XC_F_MATE_LO 6
`define XC_F_FV 5
`define XC_F_FIDX_LO 0
`define XC_ST_PAD 23

`endif

// ### hdl/xc_pkg.sv
package xc_pkg;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_MAP = 4'h1,
      OP_CTRL = 4'h2,
      OP_CLR = 4'h3
   } xc_op_t;

   typedef enum logic [1:0] {
      CS_IDLE = 2'b00,
      CS_SHIFT = 2'b01,
      CS_DONE = 2'b10
   } ctl_state_t;
endpackage : xc_pkg

// ### hdl/switch_ctrl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface switch_ctrl_link_if;
   logic ctrl_clk;
   logic sel;
   logic mosi;
   logic miso;
   modport dev (output ctrl_clk, output miso, input sel, input mosi);
   modport ctl (input ctrl_clk, input miso, output sel, output mosi);
endinterface : switch_ctrl_link_if
`default_nettype wire

// ### hdl/switch_frame_end.sv
// Function
// - Stage takes 16 working, 16 standby signals
// - Normally only working signals are switched
// - Protect command switches both sets, 480 tributaries
// - Non-blocking 480 by 480 tributary matrix
// - Outputs spread over 32 center cards
// - Return path switched with same capacity
// - Either portion failing moves both directions
// - Center card 32 replaces one failed card
// - Internal-rate clock derived from 16.384 MHz reference
// - Internal-rate sync pulse train generated
// - Optional gapped sync omits every 432nd
// - Clock and sync passed to module drivers
// - Active/standby generators, own or mate reference
// - Loop fault triggers autonomous switch and alarm
// - 6.912 MHz clock supplied to comm card
// - Comm card provides provisioning and alarm path
// - Control from comm card, error summary back
// - Control bus timed by generator clock
`timescale 1ns/1ps
`default_nettype none
`include "xc_params.svh"
module switch_frame_end
   import xc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   switch_ctrl_link_if.dev link,
   input wire logic [1:0] ref_tick,
   input wire logic [1:0] loop_fault,
   input wire logic [7:0] ing_work,
   input wire logic [7:0] ing_stby,
   output logic [7:0] ctr_a,
   output logic [7:0] ctr_b,
   output logic [4:0] ctr_port_a,
   output logic [4:0] ctr_port_b,
   input wire logic [7:0] ctr_in_a,
   input wire logic [7:0] ctr_in_b,
   output logic [7:0] eg_work,
   output logic [7:0] eg_stby,
   output logic rate_tick,
   output logic sync_pulse,
   output logic sync_gapped,
   output logic frame_start
);
   typedef struct packed {
      logic [1:0][3:0] acc;
      logic [1:0][2:0] pend;
      logic [1:0][7:0] scnt;
      logic [1:0][8:0] gcnt;
      logic active;
      logic [1:0] mate_sel;
      logic protect;
      logic gap_en;
      logic fail_valid;
      logic [4:0] fail_idx;
      logic [1:0] alarm;
      logic swevt;
      logic [7:0] slot;
      logic bank;
      logic [1:0] cdiv;
      logic cclk;
      logic [4:0] bcnt;
      logic [31:0] rx;
      logic [31:0] tx;
      logic [7:0] ctr_a;
      logic [7:0] ctr_b;
      logic [4:0] port_a;
      logic [4:0] port_b;
      logic [7:0] eg_work;
      logic [7:0] eg_stby;
      logic drv_tick;
      logic drv_sync;
      logic drv_gap;
      logic frame;
   } dev_state_t;

   dev_state_t state_ff;
   dev_state_t nxt_state;

   // Data memory per direction and bank; connection map per direction
   logic [7:0] dmem [0:1][0:1][0:`XC_SLOTS-1];
   logic [8:0] cmap [0:1][0:`XC_SLOTS-1];

   logic [1:0] gtick;
   logic [1:0] gsync;
   logic [1:0] ggap;
   logic [1:0] gsrc;
   logic rtick;
   logic map_we;
   logic map_dir;
   logic [8:0] map_pos;
   logic [8:0] map_src;
   logic [8:0] pos_b;
   logic [31:0] word;
   logic [31:0] status;

   assign pos_b = 9'(state_ff.slot) + 9'(`XC_HALF);
   assign status = {`XC_ST_PAD'h00_0000, loop_fault, state_ff.alarm, state_ff.swevt,
                    state_ff.active, state_ff.protect, state_ff.gap_en, state_ff.fail_valid};

   always_comb begin
      logic [4:0] sum;
      logic [2:0] p;
      logic rf;
      logic [4:0] pa;
      logic [4:0] pb;
      sum = 5'h00;
      p = 3'h0;
      rf = 1'b0;
      pa = 5'h00;
      pb = 5'h00;
      nxt_state = state_ff;
      map_we = 1'b0;
      map_dir = 1'b0;
      map_pos = 9'h000;
      map_src = 9'h000;
      word = {state_ff.rx[30:0], link.mosi};
      rtick = 1'b0;
      for (int g = 0; g < 2; g++) begin
         gsrc[g] = 1'(g) ^ state_ff.mate_sel[g];
         rf = ref_tick[gsrc[g]];
         gtick[g] = (state_ff.pend[g] != 3'h0);
         gsync[g] = gtick[g] && (state_ff.scnt[g] == 8'(`XC_SYNC_DIV - 1));
         ggap[g] = gsync[g] && !(state_ff.gap_en && state_ff.gcnt[g] == 9'(`XC_GAP_N - 1));
         if (ce) begin
            sum = {1'b0, state_ff.acc[g]} + 5'(`XC_NCO_INC);
            p = state_ff.pend[g] - {2'b00, gtick[g]};
            if (rf) begin
               nxt_state.acc[g] = sum[3:0];
               p = p + 3'h1 + {2'b00, sum[4]};
            end
            // Saturate: a reference faster than the clock cannot be followed
            nxt_state.pend[g] = (p > 3'h3) ? 3'h3 : p;
            if (gtick[g]) begin
               nxt_state.scnt[g] = gsync[g] ? 8'h00 : state_ff.scnt[g] + 8'h01;
            end
            if (gsync[g]) begin
               nxt_state.gcnt[g] = (state_ff.gcnt[g] == 9'(`XC_GAP_N - 1)) ? 9'h000 :
                                   state_ff.gcnt[g] + 9'h001;
            end
         end
      end
      rtick = gtick[state_ff.active];
      if (ce) begin
         nxt_state.drv_tick = 1'b0;
         nxt_state.drv_sync = 1'b0;
         nxt_state.drv_gap = 1'b0;
         nxt_state.frame = 1'b0;
         if (rtick) begin
            nxt_state.cdiv = state_ff.cdiv + 2'h1;
            if (state_ff.cdiv == 2'(`XC_CDIV_HALF - 1)) begin
               nxt_state.cdiv = 2'h0;
               nxt_state.cclk = !state_ff.cclk;
               // bus bits taken on control clock rise
               if (!state_ff.cclk && link.sel) begin
                  nxt_state.rx = word;
                  nxt_state.bcnt = state_ff.bcnt + 5'h01;
                  if (state_ff.bcnt == 5'h1f) begin
                     unique case (xc_op_t'(word[31:`XC_OP_LO]))
                        OP_MAP: begin
                           map_we = 1'b1;
                           map_dir = word[`XC_F_DIR];
                           map_pos = word[`XC_F_POS_LO +: `XC_POS_W];
                           map_src = word[`XC_F_SRC_LO +: `XC_POS_W];
                        end
                        OP_CTRL: begin
                           // one protect bit moves both directions
                           nxt_state.protect = word[`XC_F_PROT];
                           nxt_state.gap_en = word[`XC_F_GAP];
                           nxt_state.active = word[`XC_F_ACT];
                           nxt_state.mate_sel = word[`XC_F_MATE_LO +: 2];
                           nxt_state.fail_valid = word[`XC_F_FV];
                           nxt_state.fail_idx = word[`XC_F_FIDX_LO +: 5];
                        end
                        OP_CLR: begin
                           nxt_state.alarm = 2'b00;
                           nxt_state.swevt = 1'b0;
                        end
                        default: begin
                        end
                     endcase
                  end
               end else if (state_ff.cclk && link.sel && state_ff.bcnt != 5'h00) begin
                  nxt_state.tx = {state_ff.tx[30:0], 1'b0};
               end
            end
         end
         if (!link.sel) begin
            nxt_state.bcnt = 5'h00;
            nxt_state.tx = status;
         end
         // sticky alarms, set wins over clear
         for (int g = 0; g < 2; g++) begin
            if (loop_fault[gsrc[g]]) begin
               nxt_state.alarm[g] = 1'b1;
            end
         end
         if (loop_fault[gsrc[state_ff.active]] && !loop_fault[gsrc[!state_ff.active]]) begin
            nxt_state.active = !state_ff.active;
            nxt_state.swevt = 1'b1;
         end
         if (rtick) begin
            // clock and sync to module drivers
            nxt_state.drv_tick = 1'b1;
            nxt_state.drv_sync = gsync[state_ff.active];
            nxt_state.drv_gap = ggap[state_ff.active];
            nxt_state.frame = (state_ff.slot == 8'h00);
            nxt_state.slot = (state_ff.slot == 8'(`XC_HALF - 1)) ? 8'h00 : state_ff.slot + 8'h01;
            if (state_ff.slot == 8'(`XC_HALF - 1)) begin
               nxt_state.bank = !state_ff.bank;
            end
            // any source slot onto any position
            nxt_state.ctr_a = dmem[0][!state_ff.bank][cmap[0][9'(state_ff.slot)]];
            nxt_state.ctr_b = dmem[0][!state_ff.bank][cmap[0][pos_b]];
            nxt_state.eg_work = dmem[1][!state_ff.bank][cmap[1][9'(state_ff.slot)]];
            nxt_state.eg_stby = dmem[1][!state_ff.bank][cmap[1][pos_b]];
            pa = state_ff.slot[4:0];
            pb = pos_b[4:0];
            // spare center card takes the failed one
            if (state_ff.fail_valid && pa == state_ff.fail_idx) begin
               pa = 5'(`XC_SPARE_CTR);
            end
            if (state_ff.fail_valid && pb == state_ff.fail_idx) begin
               pb = 5'(`XC_SPARE_CTR);
            end
            nxt_state.port_a = pa;
            nxt_state.port_b = pb;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Memories carry no reset; positions read before written return unknown data
   always_ff @(posedge clk) begin
      if (ce && map_we) begin
         cmap[map_dir][map_pos] <= map_src;
      end
      if (ce && rtick) begin
         dmem[0][state_ff.bank][9'(state_ff.slot)] <= ing_work;
         dmem[0][state_ff.bank][pos_b] <= state_ff.protect ? ing_stby : 8'h00;
         dmem[1][state_ff.bank][9'(state_ff.slot)] <= ctr_in_a;
         dmem[1][state_ff.bank][pos_b] <= state_ff.protect ? ctr_in_b : 8'h00;
      end
   end

   assign link.ctrl_clk = state_ff.cclk;
   assign link.miso = state_ff.tx[31];
   assign ctr_a = state_ff.ctr_a;
   assign ctr_b = state_ff.ctr_b;
   assign ctr_port_a = state_ff.port_a;
   assign ctr_port_b = state_ff.port_b;
   assign eg_work = state_ff.eg_work;
   assign eg_stby = state_ff.eg_stby;
   assign rate_tick = state_ff.drv_tick;
   assign sync_pulse = state_ff.drv_sync;
   assign sync_gapped = state_ff.drv_gap;
   assign frame_start = state_ff.frame;
endmodule : switch_frame_end
`default_nettype wire

// ### hdl/second_switch_comm_card.sv
`timescale 1ns/1ps
`default_nettype none
`include "xc_params.svh"
module second_switch_comm_card
   import xc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   switch_ctrl_link_if.ctl link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [31:0] cmd_word,
   output logic rsp_valid,
   output logic [31:0] rsp_word
);
   typedef struct packed {
      ctl_state_t st;
      logic prev_clk;
      logic sel;
      logic mosi;
      logic [4:0] bcnt;
      logic [31:0] tx;
      logic [31:0] rx;
      logic rsp_valid;
      logic [31:0] rsp;
   } ctl_reg_t;

   ctl_reg_t state_ff;
   ctl_reg_t nxt_state;
   logic rise;
   logic fall;

   // bus paced only by the generator clock edges
   assign rise = link.ctrl_clk && !state_ff.prev_clk;
   assign fall = !link.ctrl_clk && state_ff.prev_clk;
   assign cmd_ready = ce && fall && (state_ff.st == CS_IDLE);

   always_comb begin
      nxt_state = state_ff;
      if (ce) begin
         nxt_state.prev_clk = link.ctrl_clk;
         nxt_state.rsp_valid = 1'b0;
         unique case (state_ff.st)
            CS_IDLE: begin
               // command launched on a falling edge
               if (fall && cmd_valid) begin
                  nxt_state.sel = 1'b1;
                  nxt_state.tx = cmd_word;
                  nxt_state.mosi = cmd_word[31];
                  nxt_state.bcnt = 5'h00;
                  nxt_state.st = CS_SHIFT;
               end
            end
            CS_SHIFT: begin
               if (rise) begin
                  nxt_state.rx = {state_ff.rx[30:0], link.miso};
                  nxt_state.bcnt = state_ff.bcnt + 5'h01;
                  if (state_ff.bcnt == 5'(`XC_WORD_W - 1)) begin
                     nxt_state.st = CS_DONE;
                  end
               end else if (fall && state_ff.bcnt != 5'h00) begin
                  nxt_state.tx = {state_ff.tx[30:0], 1'b0};
                  nxt_state.mosi = state_ff.tx[30];
               end
            end
            CS_DONE: begin
               if (fall) begin
                  nxt_state.sel = 1'b0;
                  nxt_state.mosi = 1'b0;
                  nxt_state.rsp_valid = 1'b1;
                  nxt_state.rsp = state_ff.rx;
                  nxt_state.st = CS_IDLE;
               end
            end
            default: begin
               nxt_state.st = CS_IDLE;
               nxt_state.sel = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= '{st: CS_IDLE, default: '0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign link.sel = state_ff.sel;
   assign link.mosi = state_ff.mosi;
   assign rsp_valid = state_ff.rsp_valid;
   assign rsp_word = state_ff.rsp;
endmodule : second_switch_comm_card
`default_nettype wire

// ### sim/switch_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module switch_link_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ctrl_clk,
   input wire logic sel,
   input wire logic mosi,
   input wire logic miso
);
   logic ctrl_prev_ff;
   logic [5:0] rise_cnt_ff;

   // Counts control clock rises within one selected word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_prev_ff <= 1'b0;
         rise_cnt_ff <= 6'h00;
      end else begin
         ctrl_prev_ff <= ctrl_clk;
         if (!sel) begin
            rise_cnt_ff <= 6'h00;
         end else if (ctrl_clk && !ctrl_prev_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 6'h01;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   ctrl_clk_hold_a: assert property ($changed(ctrl_clk) |=> $stable(ctrl_clk))
      else $error("control clock changed on consecutive cycles");
   sel_on_low_a: assert property ($rose(sel) |-> !ctrl_clk)
      else $error("select rose while control clock high");
   sel_off_low_a: assert property ($fell(sel) |-> !ctrl_clk)
      else $error("select fell while control clock high");
   mosi_setup_a: assert property (sel && $changed(mosi) |-> !ctrl_clk)
      else $error("command bit moved while control clock high");
   miso_setup_a: assert property (sel && $past(sel) && $changed(miso) |-> !ctrl_clk)
      else $error("status bit moved while control clock high");
   frame_bits_a: assert property ($fell(sel) |-> rise_cnt_ff == 6'h20)
      else $error("word did not carry 32 control clock rises");
   frame_gap_a: assert property ($fell(sel) |=> !sel [*3])
      else $error("next word started too soon");
   frame_min_a: assert property ($rose(sel) |=> sel [*8])
      else $error("select dropped early in a word");
endmodule : switch_link_checker
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic prot;
      logic fv;
      logic [4:0] fidx;
      logic [7:0] ca, cb;
      logic [4:0] pa, pb;
      logic [7:0] ew, es;
   } row_t;
   // Traffic held constant: working a5, standby 3c, center returns 5a and c3
   row_t rows [4] = '{
      '{1'b0, 1'b0, 5'h00, 8'ha5, 8'h00, 5'h03, 5'h13, 8'h5a, 8'h00},
      '{1'b1, 1'b0, 5'h00, 8'ha5, 8'h3c, 5'h03, 5'h13, 8'h5a, 8'hc3},
      '{1'b0, 1'b1, 5'h13, 8'ha5, 8'h00, 5'h03, 5'h1f, 8'h5a, 8'h00},
      '{1'b1, 1'b1, 5'h03, 8'ha5, 8'h3c, 5'h1f, 5'h13, 8'h5a, 8'hc3}};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [1:0] ref_tick = 2'b00;
   logic [1:0] loop_fault = 2'b00;
   logic [7:0] ing_work = 8'ha5;
   logic [7:0] ing_stby = 8'h3c;
   logic [7:0] ctr_in_a = 8'h5a;
   logic [7:0] ctr_in_b = 8'hc3;
   logic cmd_valid = 1'b0;
   logic [31:0] cmd_word = 32'h0000_0000;
   logic [7:0] ctr_a, ctr_b, eg_work, eg_stby;
   logic [4:0] ctr_port_a, ctr_port_b;
   logic rate_tick, sync_pulse, sync_gapped, frame_start, cmd_ready, rsp_valid;
   logic [31:0] rsp_word;
   logic cc_prev = 1'b0;
   logic cc_hold = 1'b0;
   logic ce_ff = 1'b1;
   int mismatches = 0;
   int comparisons = 0;
   int ticks = 0;
   int last_sync = -1;
   int last_frame = -1;
   int last_cc = -1;

   switch_ctrl_link_if i_switch_ctrl_link_if ();
   switch_frame_end i_switch_frame_end (.clk(clk), .rstn(rstn), .ce(ce),
      .link(i_switch_ctrl_link_if), .ref_tick(ref_tick), .loop_fault(loop_fault),
      .ing_work(ing_work), .ing_stby(ing_stby), .ctr_a(ctr_a), .ctr_b(ctr_b),
      .ctr_port_a(ctr_port_a), .ctr_port_b(ctr_port_b), .ctr_in_a(ctr_in_a),
      .ctr_in_b(ctr_in_b), .eg_work(eg_work), .eg_stby(eg_stby), .rate_tick(rate_tick),
      .sync_pulse(sync_pulse), .sync_gapped(sync_gapped), .frame_start(frame_start));
   second_switch_comm_card i_second_switch_comm_card (.clk(clk), .rstn(rstn), .ce(ce),
      .link(i_switch_ctrl_link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word));
   switch_link_checker i_switch_link_checker (.clk(clk), .rstn(rstn),
      .ctrl_clk(i_switch_ctrl_link_if.ctrl_clk), .sel(i_switch_ctrl_link_if.sel),
      .mosi(i_switch_ctrl_link_if.mosi), .miso(i_switch_ctrl_link_if.miso));

   always #50 clk = ~clk;

   // A sample taken while the enable held the design repeats the last one
   always @(posedge clk) ce_ff <= ce;

   // Reference events two clocks apart, the closest spacing allowed
   always @(negedge clk) ref_tick <= (ref_tick == 2'b00) ? 2'b11 : 2'b00;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic bound(input int n);
      if (n >= 5000) begin
         mismatches++;
         give_verdict();
      end
   endtask : bound

   // Word is held until taken, then the response pulse is awaited
   task automatic send(input logic [31:0] w);
      int n;
      n = 0;
      cmd_word = w;
      cmd_valid = 1'b1;
      // Ready may already stand when the call begins; waiting past it sends twice
      while (cmd_ready !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      bound(n);
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 5000);
      bound(n);
   endtask : send

   // Counts rate ticks, or only those that open a frame
   task automatic wait_on(input int k, input bit frm);
      int n;
      n = 0;
      while (k > 0 && n < 5000) begin
         @(negedge clk);
         n++;
         if (rate_tick === 1'b1 && (!frm || frame_start === 1'b1)) k--;
      end
      bound(n);
   endtask : wait_on

   always @(negedge clk) begin
      if (rstn && ce_ff) begin
         if (rate_tick === 1'b1) ticks++;
         if (sync_pulse === 1'b1) begin
            check("sync on tick", rate_tick, 1'b1);
            if (last_sync >= 0) check("sync spacing", ticks - last_sync, 224);
            last_sync = ticks;
         end
         if (frame_start === 1'b1) begin
            if (last_frame >= 0) check("frame length", ticks - last_frame, 240);
            last_frame = ticks;
         end
         if (i_switch_ctrl_link_if.ctrl_clk !== cc_prev) begin
            if (last_cc >= 0) check("ctrl clock half", ticks - last_cc, 2);
            last_cc = ticks;
         end
         cc_prev = i_switch_ctrl_link_if.ctrl_clk;
         check("ungapped sync", sync_gapped, sync_pulse);
      end
   end

   initial begin
      repeat (4) @(negedge clk);
      check("sel in reset", i_switch_ctrl_link_if.sel, 1'b0);
      check("tick in reset", rate_tick, 1'b0);
      check("ready in reset", cmd_ready, 1'b0);
      rstn = 1'b1;
      // Maps only the positions that are checked; others stay unknown
      send(32'h100C_0600);
      send(32'h13CD_F400);
      send(32'h180C_0600);
      send(32'h1BCD_EA00);
      foreach (rows[i]) begin
         send({4'h2, 17'h0_0000, rows[i].prot, 4'h0, rows[i].fv, rows[i].fidx});
         send(32'h0000_0000);
         check("status", rsp_word[8:0], {6'h00, rows[i].prot, 1'b0, rows[i].fv});
         wait_on(3, 1'b1);
         wait_on(3, 1'b0);
         check("ctr_a", ctr_a, rows[i].ca);
         check("ctr_b", ctr_b, rows[i].cb);
         check("port_a", ctr_port_a, rows[i].pa);
         check("port_b", ctr_port_b, rows[i].pb);
         check("eg_work", eg_work, rows[i].ew);
         check("eg_stby", eg_stby, rows[i].es);
      end
      // Enable low freezes every frame-end output, a standing tick too
      cc_hold = i_switch_ctrl_link_if.ctrl_clk;
      ce = 1'b0;
      repeat (20) @(negedge clk);
      check("frozen data", {ctr_a, ctr_b, eg_work, eg_stby}, 32'ha53c_5ac3);
      check("frozen ports", {ctr_port_a, ctr_port_b}, {5'h1f, 5'h13});
      check("frozen tick", rate_tick, 1'b1);
      check("frozen ctrl clock", i_switch_ctrl_link_if.ctrl_clk, cc_hold);
      ce = 1'b1;
      loop_fault = 2'b01;
      send(32'h0000_0000);
      check("auto switch", {rsp_word[8:7], rsp_word[4:3]}, 4'h7);
      check("alarm set", rsp_word[6:5], 2'b01);
      loop_fault = 2'b00;
      send(32'h3000_0000);
      send(32'h0000_0000);
      check("alarm clear", rsp_word[6:3], 4'h1);
      // Generator 1 follows side 0, so a side 1 fault must not switch; gap on
      send(32'h2000_0380);
      loop_fault = 2'b10;
      send(32'h0000_0000);
      check("mate source", rsp_word[6:3], 4'h1);
      check("gap enabled", rsp_word[1], 1'b1);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
